// *** design/card_block_command_decoder.sv ***
// Block command decoder of a memory card: block length and count, block
// reads and writes, card data programming, write protection and erase.
// Assumes a host driving CARD_CLK, CMD_IN and the data line, a byte-wide
// synchronous memory answering MEM_REQ.rd one cycle later, and a
// neighbouring response generator that consumes RESP.
//
// Summary of operation
// - Block-length command stores its argument as the byte length for later blocks.
// - Without a set block length, the default length from card data is used.
// - Single-block read sends one block of the configured length after a status reply.
// - Multiple-block read sends blocks until stop or the preset count is reached.
// - A read crossing a physical block is an error unless card data allows it.
// - Block-count command takes argument bits 15..0 for the next multi transfer.
// - A zero block count makes the next multi transfer open-ended until stop.
// - Single-block write accepts one block of configured length at the address.
// - Multiple-block write accepts blocks until stop or the preset count.
// - A write crossing a physical block is an error unless card data allows it.
// - Card-data program command updates only the programmable card-data bits.
// - Protect-set command sets the addressed group's protect bit, replies with busy.
// - Protect group size follows the group-span field of card data.
// - Protect-clear command clears the addressed group's protect bit, replies with busy.
// - Protect query returns 32 group bits then a 16-bit CRC on the data line.
// - First addressed group sits in the least significant, last sent, bit.
// - Group bits beyond the valid address range are sent as zero.
// - Indexes 32 to 34 and 37 are never executed.
// - Erase-start command records the first erase group address.
// - Erase-end command records the last erase group address.
// - Erase command erases the selected range and replies with busy.
// - Stop command ends a multi-block read, or a multi-block write outside its between-block busy, and replies with busy.
// - Addressed commands act only while selected by the card's own address.
//
// Chosen here: the strobed register port and the address map.
`include "card_block_regs.svh"

module card_block_command_decoder
  import card_block_pkg::*;
#(
  parameter int unsigned NUM_GROUPS    = 64,
  parameter int unsigned MAX_BLOCK_LEN = 2048,
  parameter int unsigned PROG_BUSY_CYC = `PROG_BUSY_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        CARD_CLK,
  input  wire logic        CMD_IN,
  input  wire logic        DAT_I,
  output logic             DAT_O,
  output logic             DAT_OE,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA,
  output mem_req_type      MEM_REQ,
  input  wire logic [7:0]  MEM_RDATA,
  output resp_type         RESP
);

  localparam int unsigned GW = $clog2(NUM_GROUPS);

  // ========================================================================
  // Pin synchronisers
  logic [2:0]  s1_q;
  logic [2:0]  s2_q;
  logic [2:0]  s3_q;
  logic        clk_lvl_q;
  wire         clk_rise = s2_q[2] & s3_q[2] & ~clk_lvl_q;
  wire         cmd_v    = s3_q[1];
  wire         dat_v    = s3_q[0];

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s1_q      <= 3'h3;
      s2_q      <= 3'h3;
      s3_q      <= 3'h3;
      clk_lvl_q <= 1'b0;
    end else begin
      s1_q <= {CARD_CLK, CMD_IN, DAT_I};
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q[2] == s3_q[2]) begin
        clk_lvl_q <= s3_q[2];
      end
    end
  end

  // ========================================================================
  // Command receiver
  // Frames with a zero transmission bit are the card's own replies and are
  // dropped, so the receiver can listen to the shared line all the time.
  logic        crx_act_q;
  logic [5:0]  crx_cnt_q;
  logic [45:0] crx_sh_q;
  logic        cmd_new_q;
  cmd_type     cmd_q;
  wire  [46:0] frame = {crx_sh_q, cmd_v};

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      crx_act_q <= 1'b0;
      crx_cnt_q <= 6'h00;
      crx_sh_q  <= '0;
      cmd_new_q <= 1'b0;
      cmd_q     <= '0;
    end else begin
      cmd_new_q <= 1'b0;
      if (clk_rise && !crx_act_q) begin
        crx_act_q <= ~cmd_v;
        crx_cnt_q <= 6'h00;
      end else if (clk_rise) begin
        crx_sh_q  <= frame[45:0];
        crx_cnt_q <= crx_cnt_q + 6'h01;
        if (crx_cnt_q == `CMD_FRAME_BITS - 6'd1) begin
          crx_act_q <= 1'b0;
          cmd_new_q <= frame[46];
          cmd_q     <= {frame[45:40], frame[39:8]};
        end
      end
    end
  end

  // ========================================================================
  // Control register fields and command decode
  logic [31:0] ctrl_q;
  logic [3:0]  st_q;
  logic        sel_q;
  logic        blklen_set_q;
  logic [11:0] blklen_q;
  logic        preset_vld_q;
  logic [15:0] preset_q;
  logic [NUM_GROUPS-1:0] wp_q;
  wire ctrl_type ctrl = ctrl_q;
  wire  [5:0]  cidx = cmd_q.index;
  wire  [31:0] carg = cmd_q.arg;
  wire         is_ill   = 1'((`ILLEGAL_CMD_MASK >> cidx) & 64'h1);
  wire         prot_cmd = (cidx == `CMD_PROT_SET) | (cidx == `CMD_PROT_CLR) |
                          (cidx == `CMD_PROT_QRY);
  wire         addr_hit = (carg[31:16] == ctrl.relative_card_address) && (carg[31:16] != 16'h0000);
  wire  [11:0] eff_len  = blklen_set_q ? blklen_q
                                       : 12'(32'h1 << ctrl.dflt_exp);
  wire  [31:0] blk_off  = carg & (`PHYS_BLK_BYTES - 32'h1);
  wire         crosses  = (blk_off + {20'h0, eff_len}) > `PHYS_BLK_BYTES;
  wire         len_bad  = (carg == 32'h0) || (carg > MAX_BLOCK_LEN);
  wire  [31:0] grp_full = carg >> (`PHYS_BLK_LOG2 + ctrl.grp_span);
  wire         grp_ok   = grp_full < NUM_GROUPS;
  wire [GW-1:0] grp_idx = grp_full[GW-1:0];
  wire         wp_hit   = grp_ok && wp_q[grp_idx];
  logic [31:0] qword;

  // Bit i covers group start+i; groups past the range read as zero.
  for (genvar i = 0; i < 32; i++) begin : g_qry
    wire [31:0] gi = grp_full + 32'(i);
    assign qword[i] = (gi < NUM_GROUPS) && (gi >= grp_full) &&
                      wp_q[gi[GW-1:0]];
  end

  // ========================================================================
  // Transfer engine state
  state_type   state_q;
  logic [11:0] xfer_len_q;
  logic [14:0] pos_q;
  logic [7:0]  sh_q;
  logic [7:0]  nb_q;
  logic [15:0] crc_q;
  logic [31:0] qw_q;
  logic [31:0] ptr_q;
  logic        fetch_q;
  logic        rd_pend_q;
  logic        src_prot_q;
  logic        dst_csd_q;
  logic        multi_q;
  logic        open_q;
  logic [15:0] left_q;
  logic        cont_q;
  logic [31:0] busy_cnt_q;
  logic [31:0] ers_start_q;
  logic [31:0] ers_end_q;
  logic [7:0]  csd_prog_q;
  logic [3:0]  err_set_q;
  mem_req_type mem_q;
  resp_type    resp_q;
  wire  [14:0] data_bits = {xfer_len_q, 3'b000};
  wire  [14:0] crc_end   = data_bits + 15'd16;
  wire  [14:0] end_pos   = data_bits + 15'd17;
  wire         last_blk  = !multi_q || (!open_q && left_q == 16'h0001);
  wire  [7:0]  wr_byte   = {sh_q[6:0], dat_v};
  wire  [31:0] ers_last  = ers_end_q >> `PHYS_BLK_LOG2;
  logic        rd_o;

  // Outgoing block: start bit, data MSB first, CRC, end bit.
  always_comb begin
    if (pos_q == 15'd0) begin
      rd_o = 1'b0;
    end else if (pos_q <= data_bits) begin
      rd_o = sh_q[7];
    end else if (pos_q <= crc_end) begin
      rd_o = crc_q[15];
    end else begin
      rd_o = 1'b1;
    end
  end

  // ========================================================================
  // Main sequencer
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      {sel_q, blklen_set_q, preset_vld_q, fetch_q, rd_pend_q} <= 5'h00;
      {src_prot_q, dst_csd_q, multi_q, open_q, cont_q} <= 5'h00;
      {blklen_q, xfer_len_q, pos_q, sh_q, nb_q} <= '0;
      {preset_q, left_q, crc_q, qw_q, ptr_q, busy_cnt_q} <= '0;
      {ers_start_q, ers_end_q, csd_prog_q, err_set_q} <= '0;
      wp_q   <= '0;
      mem_q  <= '0;
      resp_q <= '0;
    end else begin
      mem_q.rd    <= 1'b0;
      mem_q.we    <= 1'b0;
      mem_q.erase <= 1'b0;
      resp_q.stb  <= 1'b0;
      err_set_q   <= 4'h0;
      fetch_q     <= 1'b0;
      rd_pend_q   <= mem_q.rd;
      if (rd_pend_q) begin
        nb_q <= MEM_RDATA;
      end
      if (fetch_q && src_prot_q) begin
        nb_q <= qw_q[31:24];
        qw_q <= {qw_q[23:0], 8'h00};
      end else if (fetch_q) begin
        mem_q.rd   <= 1'b1;
        mem_q.addr <= ptr_q;
        ptr_q      <= ptr_q + 32'h1;
      end

      unique case (state_q)
        ST_IDLE: begin
        end
        ST_RD: begin
          if (clk_rise) begin
            pos_q <= pos_q + 15'd1;
            if (pos_q < data_bits && pos_q[2:0] == 3'h0) begin
              sh_q    <= nb_q;
              fetch_q <= 1'b1;
            end else if (pos_q <= data_bits) begin
              sh_q <= {sh_q[6:0], 1'b0};
            end
            if (pos_q == 15'd0) begin
              crc_q <= 16'h0000;
            end else if (pos_q <= data_bits) begin
              crc_q <= crc16_step(crc_q, sh_q[7]);
            end else begin
              crc_q <= {crc_q[14:0], 1'b0};
            end
            if (pos_q == end_pos + 15'd1) begin
              if (last_blk) begin
                state_q <= ST_IDLE;
              end else begin
                pos_q  <= 15'd0;
                left_q <= left_q - 16'h1;
              end
            end
          end
        end
        ST_WR_START: begin
          if (clk_rise && !dat_v) begin
            pos_q   <= 15'd1;
            state_q <= ST_WR;
          end
        end
        ST_WR: begin
          if (clk_rise) begin
            pos_q <= pos_q + 15'd1;
            if (pos_q <= data_bits) begin
              sh_q <= wr_byte;
            end
            if (pos_q <= data_bits && pos_q[2:0] == 3'h0) begin
              ptr_q <= ptr_q + 32'h1;
              if (dst_csd_q && ptr_q == `CSD_PROG_BYTE) begin
                csd_prog_q <= (csd_prog_q & ~`CSD_PROG_MASK) |
                              (wr_byte & `CSD_PROG_MASK);
              end else if (!dst_csd_q) begin
                mem_q.we    <= 1'b1;
                mem_q.addr  <= ptr_q;
                mem_q.wdata <= wr_byte;
              end
            end
            if (pos_q == end_pos) begin
              state_q    <= ST_BUSY;
              busy_cnt_q <= PROG_BUSY_CYC;
              cont_q     <= !last_blk;
              left_q     <= left_q - 16'h1;
            end
          end
        end
        ST_BUSY: begin
          busy_cnt_q <= busy_cnt_q - 32'h1;
          if (busy_cnt_q == 32'h0) begin
            state_q <= cont_q ? ST_WR_START : ST_IDLE;
          end
        end
        ST_ERASE: begin
          mem_q.erase <= 1'b1;
          mem_q.addr  <= ptr_q << `PHYS_BLK_LOG2;
          ptr_q       <= ptr_q + 32'h1;
          if (ptr_q == ers_last) begin
            state_q    <= ST_BUSY;
            busy_cnt_q <= PROG_BUSY_CYC;
            cont_q     <= 1'b0;
          end
        end
      endcase

      if (cmd_new_q && cidx == `CMD_GO_IDLE) begin
        state_q      <= ST_IDLE;
        sel_q        <= 1'b0;
        blklen_set_q <= 1'b0;
        preset_vld_q <= 1'b0;
      end else if (cmd_new_q && cidx == `CMD_SELECT) begin
        sel_q <= addr_hit;
      end else if (cmd_new_q && sel_q) begin
        resp_q.index <= cidx;
        resp_q.busy  <= 1'b0;
        resp_q.err   <= 1'b0;
        if (cidx != `CMD_BLKCNT) begin
          preset_vld_q <= 1'b0;
        end
        if (cidx == `CMD_STOP) begin
          resp_q.stb  <= 1'b1;
          resp_q.busy <= 1'b1;
          if (state_q == ST_RD) begin
            state_q <= ST_IDLE;
          end else if (state_q == ST_WR_START || state_q == ST_WR) begin
            state_q    <= ST_BUSY;
            busy_cnt_q <= PROG_BUSY_CYC;
            cont_q     <= 1'b0;
          end
        end else if (is_ill || (prot_cmd && !ctrl.prot_sup)) begin
          err_set_q[`STATUS_ILLEGAL] <= 1'b1;
        end else if (state_q == ST_IDLE) begin
          resp_q.stb <= 1'b1;
          case (cidx)
            `CMD_BLKLEN: begin
              if (len_bad) begin
                err_set_q[`STATUS_LEN] <= 1'b1;
                resp_q.err             <= 1'b1;
              end else begin
                blklen_q     <= carg[11:0];
                blklen_set_q <= 1'b1;
              end
            end
            `CMD_RD_SINGLE, `CMD_RD_MULTI, `CMD_PROT_QRY: begin
              if (cidx != `CMD_PROT_QRY && crosses && !ctrl.rd_allow) begin
                err_set_q[`STATUS_ADDR] <= 1'b1;
                resp_q.err              <= 1'b1;
              end else begin
                state_q    <= ST_RD;
                pos_q      <= 15'd0;
                fetch_q    <= 1'b1;
                ptr_q      <= carg;
                qw_q       <= qword;
                src_prot_q <= cidx == `CMD_PROT_QRY;
                xfer_len_q <= cidx == `CMD_PROT_QRY ? `QRY_LEN_BYTES : eff_len;
                multi_q    <= cidx == `CMD_RD_MULTI;
                open_q     <= !preset_vld_q || preset_q == 16'h0000;
                left_q     <= preset_q;
              end
            end
            `CMD_WR_SINGLE, `CMD_WR_MULTI, `CMD_CSD_PROG: begin
              if (cidx != `CMD_CSD_PROG && crosses && !ctrl.wr_allow) begin
                err_set_q[`STATUS_ADDR] <= 1'b1;
                resp_q.err              <= 1'b1;
              end else if (cidx != `CMD_CSD_PROG && wp_hit) begin
                err_set_q[`STATUS_PROT] <= 1'b1;
                resp_q.err              <= 1'b1;
              end else begin
                state_q    <= ST_WR_START;
                dst_csd_q  <= cidx == `CMD_CSD_PROG;
                ptr_q      <= cidx == `CMD_CSD_PROG ? 32'h0 : carg;
                xfer_len_q <= cidx == `CMD_CSD_PROG ? `CSD_LEN_BYTES : eff_len;
                multi_q    <= cidx == `CMD_WR_MULTI;
                open_q     <= !preset_vld_q || preset_q == 16'h0000;
                left_q     <= preset_q;
              end
            end
            `CMD_BLKCNT: begin
              preset_q     <= carg[15:0];
              preset_vld_q <= 1'b1;
            end
            `CMD_PROT_SET, `CMD_PROT_CLR: begin
              resp_q.busy <= 1'b1;
              state_q     <= ST_BUSY;
              busy_cnt_q  <= PROG_BUSY_CYC;
              cont_q      <= 1'b0;
              if (grp_ok) begin
                wp_q[grp_idx] <= cidx == `CMD_PROT_SET;
              end else begin
                err_set_q[`STATUS_ADDR] <= 1'b1;
                resp_q.err              <= 1'b1;
              end
            end
            `CMD_ERASE_START: begin
              ers_start_q <= carg;
            end
            `CMD_ERASE_END: begin
              ers_end_q <= carg;
            end
            `CMD_ERASE: begin
              resp_q.busy <= 1'b1;
              if (ers_start_q <= ers_end_q) begin
                state_q <= ST_ERASE;
                ptr_q   <= ers_start_q >> `PHYS_BLK_LOG2;
              end else begin
                err_set_q[`STATUS_ADDR] <= 1'b1;
                resp_q.err              <= 1'b1;
              end
            end
            default: begin
              resp_q.stb <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ========================================================================
  // Data line driver
  // Reads change the line only on a card clock edge, so the host sees each
  // bit stable for a whole card clock period.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      DAT_O  <= 1'b1;
      DAT_OE <= 1'b0;
    end else if (state_q == ST_BUSY || state_q == ST_ERASE) begin
      DAT_O  <= 1'b0;
      DAT_OE <= 1'b1;
    end else if (state_q == ST_RD) begin
      if (clk_rise) begin
        DAT_O  <= rd_o;
        DAT_OE <= pos_q <= end_pos;
      end
    end else begin
      DAT_O  <= 1'b1;
      DAT_OE <= 1'b0;
    end
  end

  // ========================================================================
  // Register port
  wire         wr_ctrl = REG_WR && REG_ADDR == `REG_CTRL;
  wire  [3:0]  st_clr  = (REG_WR && REG_ADDR == `REG_STATUS) ? REG_WDATA[3:0] : 4'h0;
  wire  [31:0] rd_mux  =
      REG_ADDR == `REG_CTRL     ? ctrl_q :
      REG_ADDR == `REG_STATUS   ? {27'h0, sel_q, st_q} :
      REG_ADDR == `REG_BLKLEN   ? {20'h0, eff_len} :
      REG_ADDR == `REG_BLKCNT   ? {15'h0, preset_vld_q, preset_q} :
      REG_ADDR == `REG_CSD_PROG ? {24'h0, csd_prog_q} : 32'h0;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl_q    <= `CTRL_RST;
      st_q      <= 4'h0;
      REG_RDATA <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= REG_WDATA;
      end
      st_q      <= (st_q & ~st_clr) | err_set_q;
      REG_RDATA <= REG_RD ? rd_mux : 32'h0;
    end
  end

  assign MEM_REQ = mem_q;
  assign RESP    = resp_q;

endmodule : card_block_command_decoder

// *** design/card_block_pkg.sv ***
// Types shared by the block command decoder and its bench.
// Takes no constants from card_block_regs.svh; the CRC polynomial 16'h1021 is written in place.
package card_block_pkg;

  // ========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_WR_START, ST_WR, ST_BUSY, ST_ERASE
  } state_type;

  typedef struct packed {
    logic [5:0]  index;
    logic [31:0] arg;
  } cmd_type;

  typedef struct packed {
    logic        rd;
    logic        we;
    logic        erase;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } mem_req_type;

  typedef struct packed {
    logic       stb;
    logic       busy;
    logic       err;
    logic [5:0] index;
  } resp_type;

  typedef struct packed {
    logic [5:0]  pad;
    logic        prot_sup;
    logic [3:0]  dflt_exp;
    logic [2:0]  grp_span;
    logic        wr_allow;
    logic        rd_allow;
    logic [15:0] relative_card_address;
  } ctrl_type;

  // ========================================================================
  // One step of the data-line CRC, most significant bit first.
  function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic bit_in);
    logic fb;
    fb = crc[15] ^ bit_in;
    return {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
  endfunction : crc16_step

endpackage : card_block_pkg

// *** design/card_block_regs.svh ***
// Offsets, field positions, reset values, command codes and timing counts
// of the block command decoder.
// Assumes a 40 MHz reference clock and byte-addressed 32-bit registers.
`ifndef CARD_BLOCK_REGS_SVH
`define CARD_BLOCK_REGS_SVH

// ==========================================================================
// Command indexes
`define CMD_GO_IDLE      6'h00
`define CMD_SELECT       6'h07
`define CMD_STOP         6'h0C
`define CMD_BLKLEN       6'h10
`define CMD_RD_SINGLE    6'h11
`define CMD_RD_MULTI     6'h12
`define CMD_BLKCNT       6'h17
`define CMD_WR_SINGLE    6'h18
`define CMD_WR_MULTI     6'h19
`define CMD_CSD_PROG     6'h1B
`define CMD_PROT_SET     6'h1C
`define CMD_PROT_CLR     6'h1D
`define CMD_PROT_QRY     6'h1E
`define CMD_ERASE_START  6'h23
`define CMD_ERASE_END    6'h24
`define CMD_ERASE        6'h26
// One bit per index: unsupported, not applicable, reserved and unusable.
`define ILLEGAL_CMD_MASK 64'h0000_03A7_8470_0000

// ==========================================================================
// Register offsets and reset values
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_BLKLEN       8'h08
`define REG_BLKCNT       8'h0C
`define REG_CSD_PROG     8'h10
`define CTRL_RST         32'h0320_0001
`define STATUS_ILLEGAL   0
`define STATUS_ADDR      1
`define STATUS_LEN       2
`define STATUS_PROT      3

// ==========================================================================
// Frame geometry
`define CMD_FRAME_BITS   6'd47
`define PHYS_BLK_LOG2    9
`define PHYS_BLK_BYTES   (32'h0000_0001 << `PHYS_BLK_LOG2)
`define CSD_LEN_BYTES    12'h010
`define CSD_PROG_BYTE    32'h0000_000E
`define CSD_PROG_MASK    8'hFC
`define QRY_LEN_BYTES    12'h004
`define CRC16_POLY       16'h1021

// ==========================================================================
// Timing
`define REF_CLK_KHZ      40000
`define PROG_BUSY_NS     2000
`define PROG_BUSY_CYC    ((`PROG_BUSY_NS * `REF_CLK_KHZ + 999999) / 1000000)

`endif

// *** verification/card_block_props.sv ***
// Port assertions of the block command decoder.
// Assumes it is bound into the decoder and sees only its ports.
module card_block_props
  import card_block_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        DAT_O,
  input wire logic        DAT_OE,
  input wire mem_req_type MEM_REQ,
  input wire resp_type    RESP
);
  // ====
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_reply_pulse: assert property (RESP.stb |=> !RESP.stb) else $error("long reply");
  a_mem_one_op: assert property ($onehot0({MEM_REQ.rd, MEM_REQ.we, MEM_REQ.erase}))
    else $error("memory ops overlap");
  a_erase_aligned: assert property (MEM_REQ.erase |-> MEM_REQ.addr[8:0] == 9'h000)
    else $error("erase unaligned");
  a_erase_steps: assert property (MEM_REQ.erase && $past(MEM_REQ.erase)
    |-> MEM_REQ.addr == $past(MEM_REQ.addr) + 32'h200) else $error("erase skipped");
  a_erase_follows: assert property (RESP.stb && RESP.index == 6'h26 && !RESP.err
    |-> ##[0:8] MEM_REQ.erase) else $error("nothing erased");
  a_illegal_silent: assert property (RESP.stb |-> !(RESP.index inside
    {[6'h14:6'h16], 6'h1A, [6'h1F:6'h22], 6'h25, [6'h27:6'h29]})) else $error("bad reply");
  a_busy_low: assert property (RESP.stb && RESP.busy && RESP.index inside {6'h1C, 6'h1D}
    |-> ##[0:2] (DAT_OE && !DAT_O)) else $error("no busy");
  a_start_low: assert property ($rose(DAT_OE) |-> !DAT_O) else $error("high start");
endmodule : card_block_props

bind card_block_command_decoder card_block_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .DAT_O(DAT_O), .DAT_OE(DAT_OE), .MEM_REQ(MEM_REQ), .RESP(RESP));

// *** verification/card_host_model.sv ***
// Host side of the card link: sends command frames and reads data blocks.
// Assumes the card drives the data line only while its enable is high.
module card_host_model (
  output logic      card_clk,
  output logic      cmd_line,
  output wire logic dat_line,
  input  wire logic dat_o,
  input  wire logic dat_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic s;
  logic h_dat = 1'b1;
  // ====
  // Link
  // The pull-up lifts a released line, so a stale bit never lingers.
  assign dat_line = dat_oe ? dat_o : h_dat;
  initial card_clk = 1'b0;
  initial cmd_line = 1'b1;
  task automatic tick();
    #100 card_clk = 1'b1;
    s = dat_line;
    #100 card_clk = 1'b0;
  endtask : tick
  task automatic send(input logic [5:0] i, input logic [31:0] a);
    logic [47:0] f;
    f = {2'b01, i, a, 8'h01};
    for (int k = 47; k >= 0; k--) begin
      cmd_line = f[k];
      tick();
    end
    cmd_line = 1'b1;
  endtask : send
  task automatic rx(output logic [31:0] v);
    s = 1'b1;
    for (int k = 0; k < 40 && s !== 1'b0; k++) tick();
    repeat (32) begin
      tick();
      v = {v[30:0], s};
    end
    repeat (18) tick();
  endtask : rx
  // One write block: start bit, data MSB first, CRC left at zero, end bit.
  task automatic tx(input logic [31:0] d);
    logic [49:0] f;
    f = {1'b0, d, 16'h0000, 1'b1};
    for (int k = 49; k >= 0; k--) begin
      h_dat = f[k];
      tick();
    end
    h_dat = 1'b1;
  endtask : tx
endmodule : card_host_model

// *** verification/tb.sv ***
// Self-checking bench of the block command decoder.
// Assumes the host model owns the card link; the bench owns registers and memory.
module tb
  import card_block_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        REF_CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, rd_d = 1'b0;
  logic        CARD_CLK, CMD_IN, DAT_I, DAT_O, DAT_OE;
  logic [7:0]  REG_ADDR = 8'h00, MEM_RDATA = 8'h00, sq[$];
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, seed = 32'h44C8DACE, v, e, rq[$], wq[$];
  mem_req_type MEM_REQ;
  resp_type    RESP;
  int          n_mismatch = 0, check_count = 0, cyc = 0, n_erase = 0;
  always #12.5 REF_CLK = ~REF_CLK;
  card_block_command_decoder #(.PROG_BUSY_CYC(4)) DUT (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .CARD_CLK(CARD_CLK), .CMD_IN(CMD_IN), .DAT_I(DAT_I), .DAT_O(DAT_O), .DAT_OE(DAT_OE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA), .RESP(RESP));
  card_host_model host (.card_clk(CARD_CLK), .cmd_line(CMD_IN), .dat_line(DAT_I),
    .dat_o(DAT_O), .dat_oe(DAT_OE));
  // ====
  // Tasks
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) rq.push_back(d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= w;
    REG_RD <= !w;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    @(posedge REF_CLK);
  endtask : bus
  task automatic cmd(input logic [5:0] i, input logic [31:0] a, input logic [7:0] r);
    if (r != 8'h00) sq.push_back(r);
    host.send(i, a);
    repeat (10) @(posedge REF_CLK);
    for (int k = 0; k < 300 && r[7] && DAT_OE === 1'b1; k++) @(posedge REF_CLK);
  endtask : cmd
  // ====
  // Monitor
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  always @(posedge REF_CLK) begin
    MEM_RDATA <= MEM_REQ.addr[7:0] ^ 8'h5A;
    rd_d <= REG_RD;
    if (MEM_REQ.erase === 1'b1) n_erase++;
    if (rd_d) chk(REG_RDATA, rq.pop_front());
    if (MEM_REQ.we === 1'b1) chk({MEM_REQ.addr[23:0], MEM_REQ.wdata}, wq.pop_front());
    if (RESP.stb === 1'b1) chk({RESP.busy, RESP.err, RESP.index}, sq.pop_front());
  end
  // ====
  // Sequence
  initial begin
    repeat (12) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    bus(1'b0, 8'h00, 32'h0320_0001);
    bus(1'b0, 8'h08, 32'h0000_0200);
    bus(1'b0, 8'hFC, 32'h0000_0000);
    seed = xs(seed);
    e = {16'h0320, seed[15:1], 1'b1};
    bus(1'b1, 8'h00, e);
    cmd(6'h07, {e[15:0], 16'h0000}, 8'h00);
    bus(1'b0, 8'h04, 32'h0000_0010);
    cmd(6'h10, 32'h0000_0004, 8'h10);
    bus(1'b0, 8'h08, 32'h0000_0004);
    // Word-aligned four-byte reads never cross a block.
    v = {17'h0, seed[30:18], 2'b00};
    cmd(6'h11, v, 8'h11);
    host.rx(e);
    chk(e, {v[7:0], v[7:0] + 8'h01, v[7:0] + 8'h02, v[7:0] + 8'h03} ^ 32'h5A5A_5A5A);
    // The same aligned word is written back before any group is protected.
    seed = xs(seed);
    e = seed;
    for (int k = 0; k < 4; k++) wq.push_back({v[23:0] + 24'(k), e[31-8*k -: 8]});
    cmd(6'h18, v, 8'h18);
    host.tx(e);
    repeat (12) @(posedge REF_CLK);
    cmd(6'h1C, 32'h0000_5000, 8'h9C);
    cmd(6'h1C, 32'h0000_7E00, 8'h9C);
    cmd(6'h1C, 32'h0000_5200, 8'h9C);
    cmd(6'h1D, 32'h0000_5200, 8'h9D);
    cmd(6'h1E, 32'h0000_5000, 8'h1E);
    host.rx(e);
    chk(e, 32'h0080_0001);
    cmd(6'h20, 32'h0000_0000, 8'h00);
    bus(1'b0, 8'h04, 32'h0000_0011);
    bus(1'b1, 8'h04, 32'h0000_0001);
    bus(1'b0, 8'h04, 32'h0000_0010);
    cmd(6'h23, 32'h0000_0400, 8'h23);
    cmd(6'h24, 32'h0000_0800, 8'h24);
    cmd(6'h26, 32'h0000_0000, 8'hA6);
    chk(n_erase, 32'd3);
    end_of_test();
  end
endmodule : tb
